// ### rtl/ovc_consts.svh
// Constants for the OTG VBUS and charger control block
//
// Operation
// - Discharge resistor follows control bit three
// - Pull-up resistor follows control bit four
// - Supply enable is OR of drive bits
// - Reset clears both drive bits
// - Supply enable output is active high
// - UART mode selects UART regulator level
// - No line state on data during UART
// - Data-detect asserts only with line state 00
// - Charger detection works during low power
// - Data-detect changes reported as interrupt events
// - Link sets connect-detect mode bit pattern
// - Link sets device detection bit patterns
// - Link sets host port SE0 pattern
// - Link sets host port attached pattern
// - Link sets host port USB operation pattern
// - Link turns charger detection off normally
// - Link classifies standard or proceeds enhanced
// - Link classifies charging or dedicated port
`ifndef OVC_CONSTS_SVH
`define OVC_CONSTS_SVH

// OTG control register field positions
`define OVC_OTG_DRV_INT_BIT   5
`define OVC_OTG_DRV_EXT_BIT   6
`define OVC_OTG_DISCHG_BIT    3
`define OVC_OTG_CHG_BIT       4
`define OVC_OTG_RESET         8'h00

// Charger control field positions
`define OVC_CHG_VSRC_BIT      0
`define OVC_CHG_ISINK_BIT     1
`define OVC_CHG_CDET_BIT      2
`define OVC_CHG_HOST_BIT      3
`define OVC_CHG_DPPD_BIT      4
`define OVC_CHG_DMPD_BIT      5
`define OVC_CHG_RESET         6'h00

// Line state that lets data-detect assert
`define OVC_LS_SE0            2'h0
// Regulator level reset values
`define OVC_REG_NORMAL        2'h0
`define OVC_UART_REG_RESET    2'h0

// Charger mode patterns {dmpd,dppd,host,cdet,isink,vsrc}
`define OVC_PAT_OFF           6'h00
`define OVC_PAT_CONNECT       6'h24
`define OVC_PAT_DEV_DET       6'h03
`define OVC_PAT_DEV_ENH       6'h0b
`define OVC_PAT_HOST_SE0      6'h3a
`define OVC_PAT_HOST_ATT      6'h3b
`define OVC_PAT_HOST_USB      6'h38

// Link settle wait in cycles between detection steps
`define OVC_SETTLE_CYCLES     8'h10

`endif

// ### rtl/ovc_pkg.sv
// Types shared by both ends of the OTG VBUS and charger control block
package ovc_pkg;
    typedef logic [7:0] ovc_otg_ctrl_t;
    typedef logic [5:0] ovc_chg_ctrl_t;
    typedef logic [1:0] ovc_level_t;
    typedef enum logic [2:0]
    {
        OVC_CLS_NONE,
        OVC_CLS_SDP,
        OVC_CLS_CDP,
        OVC_CLS_DCP,
        OVC_CLS_HOSTPORT
    } ovc_class_t;
endpackage

// ### rtl/ovc_if.sv
// Interface joining the transceiver control end and the link end
`timescale 1ns/1ps
`default_nettype none
interface ovc_if;
    import ovc_pkg::*;
    ovc_otg_ctrl_t otg_ctrl;
    ovc_chg_ctrl_t chg_ctrl;
    ovc_level_t    uart_regulator_level;
    logic          uart_mode;
    logic          suspend_n;
    logic          charger_data_detect;
    logic          detect_event;
    logic [1:0]    line_state;
    logic          line_state_valid;

    modport dev
    (
        input  otg_ctrl, chg_ctrl, uart_regulator_level, uart_mode, suspend_n,
        output charger_data_detect, detect_event, line_state, line_state_valid
    );
    modport link
    (
        output otg_ctrl, chg_ctrl, uart_regulator_level, uart_mode, suspend_n,
        input  charger_data_detect, detect_event, line_state, line_state_valid
    );
endinterface
`default_nettype wire

// ### rtl/ovc_sync3.sv
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ps
`default_nettype none
module ovc_sync3
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Pin in, filtered level out
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // Shift chain; only s2 reads s1
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level changes once second and third stages agree
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            level <= 1'b0;
        else if (s2 == s3)
            level <= s3;
    end
endmodule // ovc_sync3
`default_nettype wire

// ### rtl/ovc_device.sv
// Transceiver end: VBUS resistors, supply enable, regulator and charger status
`include "ovc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ovc_device
    import ovc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Link side
    ovc_if.dev        bus,
    // Analog pins in
    input  wire logic dp_se_pin,
    input  wire logic dm_se_pin,
    input  wire logic data_comparator_pin,
    // Analog controls out
    output logic      vbus_discharge_en,
    output logic      vbus_pullup_en,
    output logic      ext_supply_enable_out,
    output logic      volt_source_en,
    output logic      current_sink_en,
    output logic      contact_detect_en,
    output logic      host_charger_en,
    output logic      plus_line_pulldown,
    output logic      minus_line_pulldown,
    output logic [1:0] regulator_level
);
    logic       dp_s;
    logic       dm_s;
    logic       cmp_s;
    logic [1:0] ls;
    logic       next_detect;

    // Pin synchronisers; run regardless of suspend state
    ovc_sync3 u_dp  (.clock(clock), .rst(rst), .pin(dp_se_pin),           .level(dp_s));
    ovc_sync3 u_dm  (.clock(clock), .rst(rst), .pin(dm_se_pin),           .level(dm_s));
    ovc_sync3 u_cmp (.clock(clock), .rst(rst), .pin(data_comparator_pin), .level(cmp_s));

    assign ls = {dm_s, dp_s};
    // Comparator qualified by SE0 line state only, no suspend gating
    assign next_detect = cmp_s && (ls == `OVC_LS_SE0);

    // VBUS pulsing resistors straight from control bits
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            vbus_discharge_en <= 1'b0;
            vbus_pullup_en    <= 1'b0;
        end
        else
        begin
            vbus_discharge_en <= bus.otg_ctrl[`OVC_OTG_DISCHG_BIT];
            vbus_pullup_en    <= bus.otg_ctrl[`OVC_OTG_CHG_BIT];
        end
    end

    // Active-high external supply enable, cleared at reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ext_supply_enable_out <= 1'b0;
        else
            ext_supply_enable_out <= bus.otg_ctrl[`OVC_OTG_DRV_INT_BIT]
                                   | bus.otg_ctrl[`OVC_OTG_DRV_EXT_BIT];
    end

    // Charger mode controls follow bits directly
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            volt_source_en      <= 1'b0;
            current_sink_en     <= 1'b0;
            contact_detect_en   <= 1'b0;
            host_charger_en     <= 1'b0;
            plus_line_pulldown  <= 1'b0;
            minus_line_pulldown <= 1'b0;
        end
        else
        begin
            volt_source_en      <= bus.chg_ctrl[`OVC_CHG_VSRC_BIT];
            current_sink_en     <= bus.chg_ctrl[`OVC_CHG_ISINK_BIT];
            contact_detect_en   <= bus.chg_ctrl[`OVC_CHG_CDET_BIT];
            host_charger_en     <= bus.chg_ctrl[`OVC_CHG_HOST_BIT];
            plus_line_pulldown  <= bus.chg_ctrl[`OVC_CHG_DPPD_BIT];
            minus_line_pulldown <= bus.chg_ctrl[`OVC_CHG_DMPD_BIT];
        end
    end

    // Regulator switches to UART level while in UART mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            regulator_level <= `OVC_REG_NORMAL;
        else
            regulator_level <= bus.uart_mode ? bus.uart_regulator_level
                                             : `OVC_REG_NORMAL;
    end

    // Data-detect status and one-cycle change event, active in low power too
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bus.charger_data_detect <= 1'b0;
            bus.detect_event        <= 1'b0;
        end
        else
        begin
            bus.charger_data_detect <= next_detect;
            bus.detect_event        <= next_detect != bus.charger_data_detect;
        end
    end

    // Line state hidden during UART mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bus.line_state       <= 2'h0;
            bus.line_state_valid <= 1'b0;
        end
        else
        begin
            bus.line_state       <= bus.uart_mode ? 2'h0 : ls;
            bus.line_state_valid <= !bus.uart_mode;
        end
    end
endmodule // ovc_device
`default_nettype wire

// ### rtl/ovc_link.sv
// Link end: drives control bits and sequences charger detection
`include "ovc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ovc_link
    import ovc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Transceiver side
    ovc_if.link       bus,
    // User requests
    input  wire logic start_device_detect,
    input  wire logic start_host_port,
    input  wire logic usb_operation_done,
    input  wire logic [3:0] otg_bits,
    input  wire logic uart_request,
    input  wire logic [1:0] uart_level,
    input  wire logic suspend_request,
    // User status
    output ovc_class_t port_class,
    output logic       detect_busy,
    output logic [1:0] user_line_state
);
    typedef enum logic [3:0]
    {
        ST_IDLE, ST_CONNECT, ST_DEV_DET, ST_DEV_ENH, ST_DEV_USB,
        ST_DCP, ST_HOST_SE0, ST_HOST_ATT, ST_HOST_USB
    } ovc_link_state_t;

    ovc_link_state_t state;
    logic [7:0]      wait_cnt;
    logic            settled;

    assign settled = (wait_cnt == `OVC_SETTLE_CYCLES);

    // Settle counter restarts on each state change
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wait_cnt <= 8'h00;
        else if (start_device_detect || start_host_port || settled)
            wait_cnt <= 8'h00;
        else if (state != ST_IDLE)
            wait_cnt <= wait_cnt + 8'h01;
    end

    // Detection sequencer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state      <= ST_IDLE;
            port_class <= OVC_CLS_NONE;
        end
        else if (start_device_detect)
            state <= ST_CONNECT;
        else if (start_host_port)
            state <= ST_HOST_SE0;
        else if (settled)
        begin
            unique case (state)
                ST_IDLE:     state <= ST_IDLE;
                ST_CONNECT:
                    if (bus.line_state_valid && (bus.line_state != 2'h2))
                        state <= ST_DEV_DET;
                ST_DEV_DET:
                    if (bus.charger_data_detect)
                        state <= ST_DEV_ENH;
                    else
                    begin
                        port_class <= OVC_CLS_SDP;
                        state      <= ST_DEV_USB;
                    end
                ST_DEV_ENH:
                    if (bus.charger_data_detect)
                    begin
                        port_class <= OVC_CLS_DCP;
                        state      <= ST_DCP;
                    end
                    else
                    begin
                        port_class <= OVC_CLS_CDP;
                        state      <= ST_DEV_USB;
                    end
                ST_HOST_SE0:
                    if (bus.charger_data_detect)
                        state <= ST_HOST_ATT;
                ST_HOST_ATT:
                begin
                    port_class <= OVC_CLS_HOSTPORT;
                    state      <= ST_HOST_USB;
                end
                ST_DEV_USB, ST_DCP, ST_HOST_USB:
                    if (usb_operation_done)
                        state <= ST_IDLE;
            endcase
        end
    end

    // Charger bit patterns per mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bus.chg_ctrl <= `OVC_CHG_RESET;
        else
        begin
            unique case (state)
                ST_CONNECT:  bus.chg_ctrl <= `OVC_PAT_CONNECT;
                ST_DEV_DET:  bus.chg_ctrl <= `OVC_PAT_DEV_DET;
                ST_DEV_ENH:  bus.chg_ctrl <= `OVC_PAT_DEV_ENH;
                ST_HOST_SE0: bus.chg_ctrl <= `OVC_PAT_HOST_SE0;
                ST_HOST_ATT: bus.chg_ctrl <= `OVC_PAT_HOST_ATT;
                ST_HOST_USB: bus.chg_ctrl <= `OVC_PAT_HOST_USB;
                ST_IDLE, ST_DEV_USB, ST_DCP:
                    bus.chg_ctrl <= `OVC_PAT_OFF;
            endcase
        end
    end

    // OTG bits, UART and suspend controls
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bus.otg_ctrl             <= `OVC_OTG_RESET;
            bus.uart_mode            <= 1'b0;
            bus.uart_regulator_level <= `OVC_UART_REG_RESET;
            bus.suspend_n            <= 1'b1;
        end
        else
        begin
            bus.otg_ctrl             <= {1'b0, otg_bits[3], otg_bits[2], otg_bits[1],
                                         otg_bits[0], 3'h0};
            bus.uart_mode            <= uart_request;
            bus.uart_regulator_level <= uart_level;
            bus.suspend_n            <= !suspend_request;
        end
    end

    // User status; line state only used outside UART mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            detect_busy     <= 1'b0;
            user_line_state <= 2'h0;
        end
        else
        begin
            detect_busy <= (state != ST_IDLE) && (state != ST_DEV_USB)
                        && (state != ST_DCP) && (state != ST_HOST_USB);
            if (bus.line_state_valid)
                user_line_state <= bus.line_state;
        end
    end
endmodule // ovc_link
`default_nettype wire

// ### dv/ovc_checker.sv
// Concurrent checks on the device and link control interface
`include "ovc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ovc_checker
    import ovc_pkg::*;
(
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst,
    // Interface signals
    input wire ovc_otg_ctrl_t otg_ctrl,
    input wire ovc_chg_ctrl_t chg_ctrl,
    input wire ovc_level_t    uart_regulator_level,
    input wire logic          uart_mode,
    input wire logic          charger_data_detect,
    input wire logic          detect_event,
    input wire logic [1:0]    line_state,
    input wire logic          line_state_valid,
    // Device analog controls
    input wire logic          vbus_discharge_en,
    input wire logic          vbus_pullup_en,
    input wire logic          ext_supply_enable_out,
    input wire logic [5:0]    chg_pins,
    input wire logic [1:0]    regulator_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Host port waiting for an attached charging device
    sequence s_host_wait;
        chg_ctrl == `OVC_PAT_HOST_SE0;
    endsequence

    sequence s_host_left;
        chg_ctrl != `OVC_PAT_HOST_SE0;
    endsequence

    discharge_follow_a: assert property (
        vbus_discharge_en == $past(otg_ctrl[`OVC_OTG_DISCHG_BIT]))
        else $error("discharge control does not follow its bit");
    pullup_follow_a: assert property (
        vbus_pullup_en == $past(otg_ctrl[`OVC_OTG_CHG_BIT]))
        else $error("pull-up control does not follow its bit");
    supply_or_a: assert property (
        ext_supply_enable_out == ($past(otg_ctrl[`OVC_OTG_DRV_INT_BIT])
                                | $past(otg_ctrl[`OVC_OTG_DRV_EXT_BIT])))
        else $error("supply enable is not the OR of the drive bits");
    // Sampled mid-cycle so the first clock edge in reset has already cleared the registers
    reset_clear_a: assert property (@(negedge clock) disable iff (1'b0)
        rst |-> (otg_ctrl[6:5] == 2'h0) && !ext_supply_enable_out)
        else $error("drive bits or supply enable set in reset");
    uart_level_a: assert property (
        regulator_level == ($past(uart_mode) ? $past(uart_regulator_level) : 2'h0))
        else $error("regulator level wrong for the mode");
    uart_line_a: assert property (
        $past(uart_mode) |-> (line_state == 2'h0) && !line_state_valid)
        else $error("line state shown during uart mode");
    detect_gate_a: assert property (
        charger_data_detect |-> line_state == `OVC_LS_SE0)
        else $error("data detect set with line state not zero");
    detect_event_a: assert property (
        detect_event == $changed(charger_data_detect))
        else $error("detect event does not mark a status change");
    chg_follow_a: assert property (
        chg_pins == $past(chg_ctrl))
        else $error("charger controls do not follow their bits");
    legal_pattern_a: assert property (
        chg_ctrl inside {`OVC_PAT_OFF, `OVC_PAT_CONNECT, `OVC_PAT_DEV_DET, `OVC_PAT_DEV_ENH,
                         `OVC_PAT_HOST_SE0, `OVC_PAT_HOST_ATT, `OVC_PAT_HOST_USB})
        else $error("charger control holds no known mode");
    host_attach_a: assert property (
        s_host_wait ##1 s_host_left |-> chg_ctrl == `OVC_PAT_HOST_ATT)
        else $error("host port left the waiting mode wrongly");
endmodule // ovc_checker
`default_nettype wire

// ### dv/otg_vbus_charger_control_tb_top.sv
// Testbench joining both ends and checking their behaviour
`include "ovc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module otg_vbus_charger_control_tb_top
    import ovc_pkg::*;
;
    logic       clock = 0, rst = 1, dp = 0, dm = 0, cmp = 0;
    logic       start_dev = 0, start_host = 0, done = 0, uart_req = 0, susp = 0;
    logic [3:0] otg_bits = 4'h0;
    logic [1:0] uart_lvl = 2'h0, reg_lvl, uls;
    logic       dis_en, pu_en, ext_en, busy;
    wire  [5:0] chg_pins;
    int         otg_q[$];
    ovc_class_t cls;
    int         error_cnt = 0, check_count = 0, cycles = 0, i, seed;
    ovc_if      bus ();

    ovc_device u_ovc_device (.clock(clock), .rst(rst), .bus(bus), .dp_se_pin(dp),
        .dm_se_pin(dm), .data_comparator_pin(cmp), .vbus_discharge_en(dis_en),
        .vbus_pullup_en(pu_en), .ext_supply_enable_out(ext_en), .volt_source_en(chg_pins[0]),
        .current_sink_en(chg_pins[1]), .contact_detect_en(chg_pins[2]),
        .host_charger_en(chg_pins[3]), .plus_line_pulldown(chg_pins[4]),
        .minus_line_pulldown(chg_pins[5]), .regulator_level(reg_lvl));
    ovc_link u_ovc_link (.clock(clock), .rst(rst), .bus(bus), .start_device_detect(start_dev),
        .start_host_port(start_host), .usb_operation_done(done), .otg_bits(otg_bits),
        .uart_request(uart_req), .uart_level(uart_lvl), .suspend_request(susp),
        .port_class(cls), .detect_busy(busy), .user_line_state(uls));
    ovc_checker u_ovc_checker (.clock(clock), .rst(rst), .otg_ctrl(bus.otg_ctrl),
        .chg_ctrl(bus.chg_ctrl), .uart_regulator_level(bus.uart_regulator_level),
        .uart_mode(bus.uart_mode), .charger_data_detect(bus.charger_data_detect),
        .detect_event(bus.detect_event), .line_state(bus.line_state),
        .line_state_valid(bus.line_state_valid), .vbus_discharge_en(dis_en),
        .vbus_pullup_en(pu_en), .ext_supply_enable_out(ext_en), .chg_pins(chg_pins),
        .regulator_level(reg_lvl));

    // 25 MHz clock
    always #20 clock = ~clock;

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    // Bounded wait for a charger pattern, dropping the comparator in enhanced mode
    task automatic wait_chg(input logic [5:0] pat, input logic drop);
        for (int n = 0; n < 400 && bus.chg_ctrl !== pat; n++)
        begin
            @(negedge clock);
            if (drop && bus.chg_ctrl === `OVC_PAT_DEV_ENH)
                cmp = 1'b0;
        end
    endtask

    // Device detection run with end-of-use release
    task automatic run_detect(input logic c, input logic drop, input ovc_class_t exp);
        cmp = c;
        start_dev = 1'b1;
        @(negedge clock);
        start_dev = 1'b0;
        for (int n = 0; n < 400 && cls !== exp; n++)
        begin
            @(negedge clock);
            if (drop && bus.chg_ctrl === `OVC_PAT_DEV_ENH)
                cmp = 1'b0;
        end
        check("port class", 8'(cls), 8'(exp));
        done = 1'b1;
        repeat (40) @(negedge clock);
        done = 1'b0;
    endtask

    // Reference model: user control bits reach the pins two edges later
    always @(posedge clock)
    begin
        if (rst)
            otg_q.delete();
        else
            otg_q.push_back(int'(otg_bits));
        if (otg_q.size() > 2)
            void'(otg_q.pop_front());
    end

    // Model compared with the pins at every cycle
    always @(negedge clock)
    begin
        if (!rst && otg_q.size() == 2)
        begin
            check("model discharge", 8'(dis_en), 8'(otg_q[0] & 1));
            check("model pull-up", 8'(pu_en), 8'((otg_q[0] >> 1) & 1));
            check("model supply", 8'(ext_en), 8'(((otg_q[0] >> 2) | (otg_q[0] >> 3)) & 1));
        end
    end

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial
    begin
        seed = $urandom(27172);
        repeat (20) @(posedge clock);
        @(negedge clock);
        check("supply in reset", 8'(ext_en), 8'h00);
        rst = 1'b0;
        // Control bits: all sixteen codes then random ones
        for (i = 0; i < 24; i++)
        begin
            otg_bits = (i < 16) ? i[3:0] : 4'($urandom);
            repeat (3) @(negedge clock);
            check("discharge", 8'(dis_en), 8'(otg_bits[0]));
            check("pull-up", 8'(pu_en), 8'(otg_bits[1]));
            check("supply", 8'(ext_en), 8'(otg_bits[2] | otg_bits[3]));
        end
        // Uart mode levels
        for (i = 0; i < 4; i++)
        begin
            uart_lvl = i[1:0];
            uart_req = 1'b1;
            repeat (3) @(negedge clock);
            check("uart level", 8'(reg_lvl), 8'(i));
            check("line valid", 8'(bus.line_state_valid), 8'h00);
            uart_req = 1'b0;
            repeat (3) @(negedge clock);
            check("normal level", 8'(reg_lvl), 8'h00);
        end
        // Status gated by line state
        dp = 1'b1;
        cmp = 1'b1;
        repeat (10) @(negedge clock);
        check("gated detect", 8'(bus.charger_data_detect), 8'h00);
        check("user line", 8'(uls), 8'h01);
        dp = 1'b0;
        repeat (10) @(negedge clock);
        check("open detect", 8'(bus.charger_data_detect), 8'h01);
        // Device flows: standard, dedicated in low power, charging
        run_detect(1'b0, 1'b0, OVC_CLS_SDP);
        susp = 1'b1;
        run_detect(1'b1, 1'b0, OVC_CLS_DCP);
        susp = 1'b0;
        run_detect(1'b1, 1'b1, OVC_CLS_CDP);
        // Charging host port
        cmp = 1'b0;
        start_host = 1'b1;
        @(negedge clock);
        start_host = 1'b0;
        repeat (40) @(negedge clock);
        check("host wait", 8'(bus.chg_ctrl), 8'(`OVC_PAT_HOST_SE0));
        check("host busy", 8'(busy), 8'h01);
        cmp = 1'b1;
        wait_chg(`OVC_PAT_HOST_USB, 1'b0);
        check("host usb", 8'(bus.chg_ctrl), 8'(`OVC_PAT_HOST_USB));
        done = 1'b1;
        repeat (40) @(negedge clock);
        check("detect off", 8'(bus.chg_ctrl), 8'(`OVC_PAT_OFF));
        check("idle busy", 8'(busy), 8'h00);
        report_and_stop();
    end
endmodule // otg_vbus_charger_control_tb_top
`default_nettype wire
